// [rtl/modem_rx_fifo_jabber_config.v]
// Receive FIFO port, threshold and jabber timeout registers with the pin-selected mode decode.
// Assumes an APB master on ref_clk_in and synchronous line-side strobes.
//
// The implementer's own choice: the APB register port.
`timescale 1ns/10ps
`include "modem_rx_defines.vh"

module modem_rx_fifo_jabber_config #(
    parameter JABBER_TICK_CYCLES = `JABBER_TICK_CYCLES
) (
    input wire ref_clk_in,
    input wire resetn_in,
    input wire psel_in,
    input wire penable_in,
    input wire pwrite_in,
    input wire [11:0] paddr_in,
    input wire [31:0] pwdata_in,
    input wire [3:0] pstrb_in,
    output wire [31:0] prdata_out,
    output wire pready_out,
    output wire pslverr_out,
    input wire [7:0] line_rx_data_in,
    input wire line_rx_valid_in,
    output wire line_rx_ready_out,
    input wire tx_active_in,
    input wire [1:0] clock_config_pins_in,
    input wire crystal_enable_pin_in,
    input wire internal_filter_enable_in,
    output reg manchester_fieldbus_mode_out,
    output reg internal_osc_select_out,
    output reg internal_filter_route_out,
    output reg jabber_inhibit_out,
    output reg jabber_start_event_out,
    output reg rx_threshold_event_out,
    output reg irq_request_out,
    output reg [3:0] modulator_side_threshold_out
);

    // Storage and pointers
    reg [7:0] fifo_mem [0:`RX_FIFO_DEPTH-1];
    reg [3:0] wr_ptr_q;
    reg [3:0] rd_ptr_q;
    reg [3:0] level_q;
    reg [7:0] thr_cfg_q;
    reg [7:0] jabber_cfg_q;
    reg [15:0] mask_q;
    reg [22:0] tick_cnt_q;
    reg [7:0] tick_num_q;
    reg thr_hit_q;
    reg [31:0] prdata_d;
    wire [9:0] word_idx;
    wire rd_access;
    wire wr_access;
    wire pop;
    wire push;
    wire full;
    wire empty;
    wire [3:0] demod_thr;
    wire level_hit;
    wire [15:0] port_word;

    assign word_idx = paddr_in[11:2];
    assign rd_access = psel_in & penable_in & ~pwrite_in;
    assign wr_access = psel_in & penable_in & pwrite_in;
    assign demod_thr = thr_cfg_q[`DEMOD_THR_MSB:`DEMOD_THR_LSB];  // [R10]
    assign full = (level_q == 4'd15);  // [R3]
    assign empty = (level_q == 4'h0);  // [R4]
    // A zero threshold never fires, so an unprogrammed field stays quiet
    assign level_hit = (demod_thr != 4'h0) && (level_q >= demod_thr);  // [R2]
    // Popping a read of an empty FIFO is harmless: nothing is removed
    assign pop = rd_access && (word_idx == {2'b00, `RX_FIFO_PORT_IDX}) && !empty;  // [R22]
    assign push = line_rx_valid_in && !full;
    assign line_rx_ready_out = !full;
    assign pready_out = 1'b1;
    assign pslverr_out = 1'b0;
    assign prdata_out = prdata_d;

    // Read word of the receive FIFO port: level, flags, parity, oldest byte
    // Empty reads the documented reset word, so unwritten memory never leaks into parity
    assign port_word = {level_q, level_hit, full, empty,
                        empty ? 1'b0 : ~^fifo_mem[rd_ptr_q],
                        empty ? 8'h00 : fifo_mem[rd_ptr_q]};  // [R1] [R5] [R6] [R7]

    // Read mux; unmapped words read zero
    always @* begin
        prdata_d = 32'h0000_0000;
        case (word_idx)
            {2'b00, `RX_FIFO_PORT_IDX}: prdata_d = {16'h0000, port_word};  // [R7]
            {2'b00, `FIFO_THRESHOLD_CONFIG_IDX}: prdata_d = {24'h000000, thr_cfg_q};  // [R11]
            {2'b00, `JABBER_TIMEOUT_CONFIG_IDX}: prdata_d = {24'h000000, jabber_cfg_q};  // [R13]
            {2'b00, `IRQ_MASK_IDX}: prdata_d = {16'h0000, mask_q};
            {2'b00, `MODE_STATUS_IDX}: prdata_d = {28'h0000000, jabber_inhibit_out,
                internal_filter_route_out, internal_osc_select_out, manchester_fieldbus_mode_out};
            default: prdata_d = 32'h0000_0000;
        endcase
    end

    // Byte store; memory needs no reset as empty masks the data
    always @(posedge ref_clk_in) begin
        if (push) begin
            fifo_mem[wr_ptr_q] <= line_rx_data_in;
        end
    end

    // Pointers and level, with push and pop allowed in one cycle
    always @(posedge ref_clk_in or negedge resetn_in) begin
        if (!resetn_in) begin
            wr_ptr_q <= 4'h0;
            rd_ptr_q <= 4'h0;
            level_q <= 4'h0;
            thr_hit_q <= 1'b0;
            rx_threshold_event_out <= 1'b0;
        end else begin
            if (push) begin
                wr_ptr_q <= (wr_ptr_q == 4'd14) ? 4'h0 : wr_ptr_q + 4'h1;
            end
            if (pop) begin
                rd_ptr_q <= (rd_ptr_q == 4'd14) ? 4'h0 : rd_ptr_q + 4'h1;  // [R22]
            end
            if (push && !pop) begin
                level_q <= level_q + 4'h1;
            end else if (pop && !push) begin
                level_q <= level_q - 4'h1;
            end
            thr_hit_q <= level_hit;
            rx_threshold_event_out <= level_hit & ~thr_hit_q;  // [R2]
        end
    end

    // Configuration registers, written on the APB access edge with strobes
    always @(posedge ref_clk_in or negedge resetn_in) begin
        if (!resetn_in) begin
            thr_cfg_q <= `FIFO_THRESHOLD_RESET;
            jabber_cfg_q <= `JABBER_TIMEOUT_RESET;
            mask_q <= `IRQ_MASK_RESET;
        end else if (wr_access) begin
            if (word_idx == {2'b00, `FIFO_THRESHOLD_CONFIG_IDX} && pstrb_in[0]) begin
                thr_cfg_q <= pwdata_in[7:0];  // [R9] [R10] [R11]
            end
            if (word_idx == {2'b00, `JABBER_TIMEOUT_CONFIG_IDX} && pstrb_in[0]) begin
                jabber_cfg_q <= pwdata_in[7:0];  // [R13]
            end
            if (word_idx == {2'b00, `IRQ_MASK_IDX}) begin
                if (pstrb_in[0]) begin
                    mask_q[7:0] <= pwdata_in[7:0];
                end
                if (pstrb_in[1]) begin
                    mask_q[15:8] <= pwdata_in[15:8];
                end
            end
        end
    end

    // Jabber inhibitor: counts 2.048 ms ticks of continuous transmission
    always @(posedge ref_clk_in or negedge resetn_in) begin
        if (!resetn_in) begin
            tick_cnt_q <= 23'h000000;
            tick_num_q <= 8'h00;
            jabber_inhibit_out <= 1'b0;
            jabber_start_event_out <= 1'b0;
        end else begin
            jabber_start_event_out <= 1'b0;
            if (!tx_active_in) begin
                tick_cnt_q <= 23'h000000;
                tick_num_q <= 8'h00;
                jabber_inhibit_out <= 1'b0;
            end else if (!jabber_inhibit_out && jabber_cfg_q != 8'h00) begin
                // A zero timeout leaves the inhibitor disabled
                if (tick_num_q == jabber_cfg_q) begin
                    jabber_inhibit_out <= 1'b1;  // [R12]
                    jabber_start_event_out <= 1'b1;  // [R21]
                end else if (tick_cnt_q == JABBER_TICK_CYCLES[22:0] - 23'h000001) begin
                    tick_cnt_q <= 23'h000000;
                    tick_num_q <= tick_num_q + 8'h01;  // [R12]
                end else begin
                    tick_cnt_q <= tick_cnt_q + 23'h000001;
                end
            end
        end
    end

    // Pin decodes and gated interrupt request
    always @(posedge ref_clk_in or negedge resetn_in) begin
        if (!resetn_in) begin
            manchester_fieldbus_mode_out <= 1'b0;
            internal_osc_select_out <= 1'b0;
            internal_filter_route_out <= 1'b0;
            irq_request_out <= 1'b0;
            modulator_side_threshold_out <= 4'h0;
        end else begin
            manchester_fieldbus_mode_out <= clock_config_pins_in[1];  // [R14] [R16]
            internal_osc_select_out <= ~crystal_enable_pin_in & (clock_config_pins_in[0]
                                       | clock_config_pins_in[1]);  // [R18]
            internal_filter_route_out <= internal_filter_enable_in;  // [R19]
            modulator_side_threshold_out <= thr_cfg_q[`MOD_THR_MSB:`MOD_THR_LSB];  // [R9]
            irq_request_out <= (rx_threshold_event_out & ~mask_q[`MASK_RX_THR_BIT])  // [R20]
                | (jabber_start_event_out & ~mask_q[`MASK_JAB_START_BIT]);  // [R21]
        end
    end

endmodule // modem_rx_fifo_jabber_config

// [shared/modem_rx_defines.vh]
// Register map, field positions, reset values and timing counts of the modem receive block.
// Assumes a 20 MHz ref_clk_in and a 32-bit APB master.
// Overview of operation
// [R1] Receive FIFO register is read only; entry count sits in bits 15-12.
// [R2] Bit 11 is set once the FIFO fill reaches the programmed threshold.
// [R3] Bit 10 is set while the FIFO holds its maximum entries.
// [R4] Bit 9 is set while the FIFO is empty; it reads 1 after reset.
// [R5] Bit 8 is the odd parity of the data byte returned.
// [R6] Bits 7-0 carry the oldest byte received from the line.
// [R7] Receive FIFO register decodes at offset 24h, reset value 0x0200.
// [R8] Host programs each threshold field within 1 to 15.
// [R9] Threshold register bits 7-4 set the modulator-side FIFO threshold.
// [R10] Threshold register bits 3-0 set the demodulator-side FIFO threshold.
// [R11] Threshold register at 25h, reset 0x0000, upper byte reads zero.
// [R12] Jabber inhibitor ends transmission after value times 2.048 ms.
// [R13] Jabber timeout register at 27h, reset zero, upper byte reads zero.
// [R14] Clock configuration pins select FSK loop mode or Manchester fieldbus mode.
// [R15] FSK mode uses 1200/2200 Hz tones.
// [R16] Fieldbus mode exchanges Manchester data at 31.25 kbit/s.
// [R17] System supplies 1.2288 or 3.686 MHz in FSK, 4 MHz in fieldbus.
// [R18] Clock pins with crystal enable choose internal oscillator or external clock.
// [R19] Filter enable high routes receive through the internal bandpass filter.
// [R20] Mask bit 7 set stops the receive threshold event reaching the interrupt.
// [R21] Jabber start event raised when inhibitor engages; mask bit 13 blocks it.
// [R22] Each receive FIFO read pops the byte and updates level and flags.
`ifndef MODEM_RX_DEFINES_VH
`define MODEM_RX_DEFINES_VH

// Printed offsets are word indices; byte address is four times the index
`define RX_FIFO_PORT_IDX 8'h24
`define FIFO_THRESHOLD_CONFIG_IDX 8'h25
`define JABBER_TIMEOUT_CONFIG_IDX 8'h27
`define IRQ_MASK_IDX 8'h28
`define MODE_STATUS_IDX 8'h29
`define RX_FIFO_PORT_RESET 16'h0200
// Threshold and jabber upper bytes are reserved and read zero, so only their stored low byte needs a reset value; the mask resets all 16 bits
`define FIFO_THRESHOLD_RESET 8'h00
`define JABBER_TIMEOUT_RESET 8'h00
`define IRQ_MASK_RESET 16'h0024

// Field positions
`define LEVEL_MSB 15
`define LEVEL_LSB 12
`define LEVEL_FLAG_BIT 11
`define FULL_FLAG_BIT 10
`define EMPTY_FLAG_BIT 9
`define PARITY_BIT 8
`define MOD_THR_MSB 7
`define MOD_THR_LSB 4
`define DEMOD_THR_MSB 3
`define DEMOD_THR_LSB 0
`define MASK_RX_THR_BIT 7
`define MASK_JAB_START_BIT 13

// FIFO depth: largest count the 4-bit level field can report
`define RX_FIFO_DEPTH 15

// Jabber tick of 2.048 ms at 20 MHz
`define CLK_PERIOD_PS 50000
`define JABBER_TICK_NS 2048000
`define JABBER_TICK_CYCLES ((`JABBER_TICK_NS * 1000) / `CLK_PERIOD_PS)

`endif

// [verif/modem_rx_line_src.sv]
// Line-side byte source standing in for the modem demodulator.
// Assumes the block pulls a byte on an edge where valid and ready are both high.
`timescale 1ns/10ps
module modem_rx_line_src (
    input wire ref_clk_in,
    input wire line_rx_ready_out,
    output reg [7:0] line_rx_data_in,
    output reg line_rx_valid_in
);
    initial begin
        line_rx_valid_in = 1'b0;
        line_rx_data_in = 8'hff;
    end
    // Hold byte until taken; inverted data afterwards so no stale value looks valid
    task send(input [7:0] b);
        begin
            @(posedge ref_clk_in);
            line_rx_valid_in <= 1'b1;
            line_rx_data_in <= b;
            do @(posedge ref_clk_in); while (line_rx_ready_out !== 1'b1);
            line_rx_valid_in <= 1'b0;
            line_rx_data_in <= ~b;
        end
    endtask
endmodule // modem_rx_line_src

// [verif/modem_rx_properties.sv]
// Checker for the receive port, config registers and pin decode.
// Assumes bind onto the block top; FIFO level is shadowed from port traffic.
`timescale 1ns/10ps
module modem_rx_properties (
    input wire ref_clk_in, input wire resetn_in, input wire psel_in, input wire penable_in,
    input wire pwrite_in, input wire [11:0] paddr_in, input wire [31:0] prdata_out,
    input wire pslverr_out, input wire line_rx_valid_in, input wire line_rx_ready_out,
    input wire [1:0] clock_config_pins_in, input wire crystal_enable_pin_in,
    input wire internal_filter_enable_in, input wire manchester_fieldbus_mode_out,
    input wire internal_osc_select_out, input wire internal_filter_route_out,
    input wire jabber_inhibit_out, input wire jabber_start_event_out
);
    default clocking @(posedge ref_clk_in); endclocking
    default disable iff (!resetn_in);
    reg [3:0] lvl_q;
    wire rd_acc = psel_in & penable_in & !pwrite_in;
    wire pop = rd_acc & (paddr_in == 12'h090) & (lvl_q != 4'h0);
    wire push = line_rx_valid_in & line_rx_ready_out;
    // Shadow level; independent of the design's own pointers
    always @(posedge ref_clk_in or negedge resetn_in) begin
        if (!resetn_in) lvl_q <= 4'h0;
        else lvl_q <= lvl_q + {3'h0, push} - {3'h0, pop};
    end
    sequence port_rd; rd_acc && paddr_in == 12'h090; endsequence
    sequence cfg_rd; rd_acc && (paddr_in == 12'h094 || paddr_in == 12'h09c); endsequence
    a_level_field: assert property (port_rd |-> prdata_out[15:12] == lvl_q)
        else $error("level field off");
    a_full_flag: assert property (port_rd |-> prdata_out[10] == (lvl_q == 4'hf))
        else $error("full flag off");
    a_empty_flag: assert property (port_rd |-> prdata_out[9] == (lvl_q == 4'h0))
        else $error("empty flag off");
    a_parity_odd: assert property (port_rd ##0 lvl_q != 4'h0 |-> ^prdata_out[8:0])
        else $error("parity not odd");
    a_ready_full: assert property (line_rx_ready_out == (lvl_q != 4'hf))
        else $error("ready vs full");
    a_cfg_upper_zero: assert property (cfg_rd |-> prdata_out[31:8] == 24'h0)
        else $error("upper byte set");
    a_no_slverr: assert property (psel_in && penable_in |-> !pslverr_out)
        else $error("slave error");
    a_mode_pins: assert property ($past(resetn_in) |->
        manchester_fieldbus_mode_out == $past(clock_config_pins_in[1]))
        else $error("mode decode");
    a_osc_pins: assert property ($past(resetn_in) |-> internal_osc_select_out ==
        ($past(clock_config_pins_in) != 2'b00 && !$past(crystal_enable_pin_in)))
        else $error("osc decode");
    a_filter_route: assert property ($past(resetn_in) |->
        internal_filter_route_out == $past(internal_filter_enable_in))
        else $error("filter route");
    a_jab_start: assert property ($rose(jabber_inhibit_out) |-> jabber_start_event_out ##1
        !jabber_start_event_out)
        else $error("jabber start pulse");
endmodule // modem_rx_properties
bind modem_rx_fifo_jabber_config modem_rx_properties chk_i (.*);

// [verif/testbench.sv]
// Register-level bench for the receive block over APB.
// Assumes zero-wait slave and a shortened jabber tick of 8 cycles.
`timescale 1ns/10ps
module testbench;
    reg ref_clk_in = 0, resetn_in = 0, psel_in = 0, penable_in = 0, pwrite_in = 0, tx_active_in = 0;
    reg crystal_enable_pin_in = 0, internal_filter_enable_in = 1;
    reg [1:0] clock_config_pins_in = 2'b10;
    reg [11:0] paddr_in = 12'h0;
    reg [31:0] pwdata_in = 32'h0, q;
    wire [3:0] pstrb_in = 4'hf;
    wire [31:0] prdata_out;
    wire [7:0] line_rx_data_in;
    wire [3:0] modulator_side_threshold_out;
    wire pready_out, pslverr_out, line_rx_valid_in, line_rx_ready_out, manchester_fieldbus_mode_out;
    wire internal_osc_select_out, internal_filter_route_out, jabber_inhibit_out;
    wire jabber_start_event_out, rx_threshold_event_out, irq_request_out;
    int num_errors = 0, num_checks = 0, n;
    modem_rx_fifo_jabber_config #(.JABBER_TICK_CYCLES(8)) DUT (.*);
    modem_rx_line_src src (.*);
    always #25 ref_clk_in = ~ref_clk_in;
    // One APB transfer; read data taken at the edge pready is seen
    task xfer(input w, input [11:0] a, input [31:0] d);
        begin
            @(posedge ref_clk_in);
            psel_in <= 1'b1; pwrite_in <= w; paddr_in <= a; pwdata_in <= d;
            @(posedge ref_clk_in);
            penable_in <= 1'b1;
            do @(posedge ref_clk_in); while (pready_out !== 1'b1);
            q = prdata_out;
            psel_in <= 1'b0; penable_in <= 1'b0;
        end
    endtask
    task chk(input [8*10:1] nm, input [31:0] e, input [31:0] g);
        begin
            num_checks++;
            if (g !== e) begin
                num_errors++;
                $display("wrong value %0s exp %h got %h", nm, e, g);
            end
        end
    endtask
    function [31:0] pw(input [3:0] l, input [7:0] d);
        pw = {16'h0, l, l >= 4'h5, l == 4'hf, l == 4'h0, ~^d, d};
    endfunction
    task summarize;
        begin
            $display("checks %0d errors %0d", num_checks, num_errors);
            if (num_errors == 0 && num_checks > 0) $display("Regression OK");
            else $display("Regression broken");
            $finish;
        end
    endtask
    initial begin
        #200000 num_errors++;
        summarize;
    end
    initial begin
        repeat (12) @(posedge ref_clk_in);
        resetn_in <= 1'b1;
        xfer(0, 12'h090, 0); chk("port rst", 32'h200, q);
        xfer(0, 12'h094, 0); chk("thr rst", 32'h0, q);
        xfer(0, 12'h09c, 0); chk("jab rst", 32'h0, q);
        xfer(0, 12'hffc, 0); chk("unmapped", 32'h0, q);
        chk("pins", 3'b111, {manchester_fieldbus_mode_out, internal_osc_select_out,
            internal_filter_route_out});
        $display("test reset done");
        xfer(1, 12'h094, 32'hffff_ff35); xfer(1, 12'h090, 32'h1234);
        xfer(0, 12'h094, 0); chk("thr", 32'h35, q);
        chk("mod thr", 4'h3, modulator_side_threshold_out);
        $display("test config done");
        for (n = 0; n < 15; n++) src.send(8'h5a + n * 8'h13);
        @(posedge ref_clk_in); chk("ready", 1'b0, line_rx_ready_out);
        for (n = 0; n < 15; n++) begin
            xfer(0, 12'h090, 0); chk("port", pw(15 - n, 8'h5a + n * 8'h13), q);
        end
        xfer(0, 12'h090, 0); chk("port end", 32'h200, q & ~32'h100);
        $display("test fifo done");
        xfer(1, 12'h09c, 32'h2); @(posedge ref_clk_in); tx_active_in <= 1'b1;
        n = 0;
        // Inhibit sets on edge N*8+1; it is seen settled one edge later
        do begin @(posedge ref_clk_in); n++; end while (jabber_inhibit_out !== 1'b1 && n < 100);
        chk("jab time", 2 * 8 + 2, n);
        tx_active_in <= 1'b0; clock_config_pins_in <= 2'b00; internal_filter_enable_in <= 1'b0;
        repeat (3) @(posedge ref_clk_in);
        chk("jab off", 1'b0, jabber_inhibit_out);
        chk("pins off", 3'b000, {manchester_fieldbus_mode_out, internal_osc_select_out,
            internal_filter_route_out});
        $display("test jabber done");
        summarize;
    end
endmodule // testbench
